// ---- core/dra_pkg.sv ----
// dra_pkg: constants, state encoding and carrier types of the dram refresh arbiter
// assumes one 200 MHz system clock; the cpu clock output arrives as a synchronous level
// What this block does
// - state advances on each falling edge of the 10 MHz cpu clock output
// - eight states in three bits; inputs: state, dram select, refresh latch
// - refresh request equals top state bit, row strobe equals middle bit
// - idle is 111, both outputs high, until select low or latch set
// - select low in idle: 101, 100, back to 111; row strobe two cycles
// - idle, select high, latch set: go to 010, refresh low, row high
// - refresh and row strobe never fall together; refresh falls first
// - after 010 go 001, 000 (row strobe low twice), then 011
// - refresh request low clears the pending refresh latch
// - select low in 010, 001, 000 or 011 pulls sync ready low
// - 011 with select high returns to idle 111
// - 011 with select low goes to 110, refresh high, row high
// - from 110 release sync ready and continue to 101, 100
// - idle with select and latch both active: access wins, refresh later
// - column strobe request is driven identical to row strobe request
// - arbiter starts idle at power-up
package dra_pkg;

	localparam int unsigned SYS_CLK_MHZ    = 200;
	localparam int unsigned CPU_CLK_MHZ    = 10;
	// system cycles per cpu clock; the edge detector needs at least two
	localparam int unsigned CPU_CLK_RATIO  = SYS_CLK_MHZ / CPU_CLK_MHZ;
	localparam int unsigned STATE_W        = 3;
	localparam int unsigned REFRESH_ROWS   = 256;
	localparam int unsigned REFRESH_MS     = 4;
	// falls spent in one refresh: arm, two strobes, recover
	localparam int unsigned REFRESH_STATES = 4;

	// implicit encoding 0..7 in this order gives the documented state numbers
	typedef enum logic [STATE_W-1:0] {
		DRA_REF_STROBE_B,   // 000
		DRA_REF_STROBE_A,   // 001
		DRA_REF_ARM,        // 010
		DRA_REF_RECOVER,    // 011
		DRA_ACC_STROBE_B,   // 100
		DRA_ACC_STROBE_A,   // 101
		DRA_ACC_REARM,      // 110
		DRA_IDLE            // 111
	} dra_state_t;

	localparam int unsigned BIT_HI  = 2;
	localparam int unsigned BIT_MID = 1;

	// strobes toward the external dram address controller, all active low
	typedef struct packed {
		logic refresh_request_n;
		logic row_strobe_request_n;
		logic column_strobe_request_n;
	} dra_ctl_t;

	localparam dra_ctl_t   CTL_RESET      = '{1'b1, 1'b1, 1'b1};
	localparam dra_state_t STATE_RESET    = DRA_IDLE;
	localparam logic       READY_RESET    = 1'b1;
	localparam logic       LATCH_RESET    = 1'b0;
	localparam logic       CPU_CLK_RESET  = 1'b0;

endpackage

// ---- core/dra_arbiter.sv ----
// dra_arbiter: shares the dram controller between cpu accesses and periodic refresh
// assumes i_cpu_clock_output, i_dram_select_n and i_timer_refresh_pulse are synchronous to i_clk_sys
`timescale 1ns/1ps
module dra_arbiter (
	// system
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst,
	// processor side
	input  wire logic            i_cpu_clock_output,
	input  wire logic            i_dram_select_n,
	output logic                 o_sync_ready,
	// refresh interval timer
	input  wire logic            i_timer_refresh_pulse,
	output logic                 o_latched_refresh_view,
	// dram address controller
	output dra_pkg::dra_ctl_t    o_dram_ctl,
	output dra_pkg::dra_state_t  o_state
);
	import dra_pkg::*;

	// check bounds: two cpu clocks of system cycles, and the longest refresh in falls
	localparam int                 FALL_WAIT_MAX = 2 * CPU_CLK_RATIO;
	localparam logic [STATE_W-1:0] REF_FALLS_MAX = STATE_W'(REFRESH_STATES);

	logic        cpu_clk_prev_r;
	logic        cpu_fall;
	dra_state_t  state_r;
	dra_state_t  state_nxt;
	logic        ready_r;
	logic        ready_nxt;
	dra_ctl_t    ctl_r;
	dra_ctl_t    ctl_nxt;
	logic        latch_r;
	logic        sel_low;
	logic        in_refresh;

	// falling edge of the cpu clock, seen one system cycle late
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cpu_clk_prev_r <= CPU_CLK_RESET;
		end else begin
			cpu_clk_prev_r <= i_cpu_clock_output;
		end
	end

	assign cpu_fall   = cpu_clk_prev_r & ~i_cpu_clock_output;
	assign sel_low    = ~i_dram_select_n;
	assign in_refresh = (state_r == DRA_REF_ARM) || (state_r == DRA_REF_STROBE_A)
		|| (state_r == DRA_REF_STROBE_B) || (state_r == DRA_REF_RECOVER);

	// next state from state bits, dram select and the refresh latch only
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DRA_IDLE: begin
				if (sel_low) begin
					state_nxt = DRA_ACC_STROBE_A;
				end else if (latch_r) begin
					state_nxt = DRA_REF_ARM;
				end else begin
					state_nxt = DRA_IDLE;
				end
			end
			DRA_ACC_STROBE_A: state_nxt = DRA_ACC_STROBE_B;
			DRA_ACC_STROBE_B: state_nxt = DRA_IDLE;
			DRA_REF_ARM:      state_nxt = DRA_REF_STROBE_A;
			DRA_REF_STROBE_A: state_nxt = DRA_REF_STROBE_B;
			DRA_REF_STROBE_B: state_nxt = DRA_REF_RECOVER;
			DRA_REF_RECOVER: begin
				if (sel_low) begin
					state_nxt = DRA_ACC_REARM;
				end else begin
					state_nxt = DRA_IDLE;
				end
			end
			DRA_ACC_REARM:    state_nxt = DRA_ACC_STROBE_A;
			default:          state_nxt = DRA_IDLE;
		endcase
	end

	// wait states only while a cpu access collides with refresh
	always_comb begin
		ready_nxt = ~(sel_low & in_refresh);
	end

	// strobes follow the state bits; column strobe is a copy of row strobe
	always_comb begin
		ctl_nxt.refresh_request_n      = state_nxt[BIT_HI];
		ctl_nxt.row_strobe_request_n   = state_nxt[BIT_MID];
		ctl_nxt.column_strobe_request_n = state_nxt[BIT_MID];
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_r <= STATE_RESET;
		end else if (cpu_fall) begin
			state_r <= state_nxt;
		end
	end

	// separate flops so outputs leave straight from registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctl_r <= CTL_RESET;
		end else if (cpu_fall) begin
			ctl_r <= ctl_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ready_r <= READY_RESET;
		end else if (cpu_fall) begin
			ready_r <= ready_nxt;
		end
	end

	// pending refresh: set by timer, cleared while refresh request is low
	// runs on every system edge so a short timer pulse is never missed
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			latch_r <= LATCH_RESET;
		end else if (i_timer_refresh_pulse) begin
			latch_r <= 1'b1;
		end else if (!ctl_r.refresh_request_n) begin
			latch_r <= 1'b0;
		end
	end

	assign o_sync_ready           = ready_r;
	assign o_latched_refresh_view = latch_r;
	assign o_dram_ctl             = ctl_r;
	assign o_state                = state_r;

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_state_hold:
	assert property (!cpu_fall |=> $stable(state_r) && $stable(ctl_r) && $stable(ready_r))
	else $error("state moved without a cpu clock fall");

	chk_bits_outputs:
	assert property (ctl_r.refresh_request_n == state_r[BIT_HI]
		&& ctl_r.row_strobe_request_n == state_r[BIT_MID]
		&& ctl_r.column_strobe_request_n == ctl_r.row_strobe_request_n)
	else $error("strobes differ from state bits");

	chk_idle_wait:
	assert property (cpu_fall && state_r == DRA_IDLE && i_dram_select_n && !latch_r
		|=> state_r == DRA_IDLE && ctl_r.refresh_request_n && ctl_r.row_strobe_request_n)
	else $error("idle left without cause");

	chk_access_seq:
	assert property (cpu_fall && state_r == DRA_IDLE && !i_dram_select_n
		|=> state_r == DRA_ACC_STROBE_A ##[1:FALL_WAIT_MAX] state_r == DRA_ACC_STROBE_B)
	else $error("access sequence broken");

	chk_refresh_arm:
	assert property (cpu_fall && state_r == DRA_IDLE && i_dram_select_n && latch_r
		|=> state_r == DRA_REF_ARM && !ctl_r.refresh_request_n && ctl_r.row_strobe_request_n)
	else $error("refresh arm missed");

	chk_no_joint_fall:
	assert property (!($fell(ctl_r.refresh_request_n) && $fell(ctl_r.row_strobe_request_n)))
	else $error("refresh and row strobe fell together");

	chk_refresh_seq:
	assert property (cpu_fall && state_r == DRA_REF_STROBE_B |=> state_r == DRA_REF_RECOVER)
	else $error("refresh recover not reached");

	chk_latch_clear:
	assert property (!ctl_r.refresh_request_n && !i_timer_refresh_pulse |=> !latch_r)
	else $error("latch not cleared by refresh request");

	chk_wait_insert:
	assert property (cpu_fall && in_refresh && !i_dram_select_n |=> !o_sync_ready)
	else $error("no wait state during refresh collision");

	chk_recover_exit:
	assert property (cpu_fall && state_r == DRA_REF_RECOVER && i_dram_select_n
		|=> state_r == DRA_IDLE && ctl_r.refresh_request_n)
	else $error("recover did not return idle");

	chk_rearm_path:
	assert property (cpu_fall && state_r == DRA_REF_RECOVER && !i_dram_select_n
		|=> state_r == DRA_ACC_REARM)
	else $error("recover did not rearm access");

	chk_ready_release:
	assert property (cpu_fall && state_r == DRA_ACC_REARM |=> o_sync_ready && state_r == DRA_ACC_STROBE_A)
	else $error("rearm did not release ready");

	chk_access_priority:
	assert property (cpu_fall && state_r == DRA_IDLE && !i_dram_select_n && latch_r
		|=> state_r == DRA_ACC_STROBE_A && latch_r)
	else $error("refresh took priority over access");

	chk_ready_high:
	assert property (cpu_fall && !in_refresh |=> o_sync_ready)
	else $error("ready low outside refresh");

	chk_set_wins:
	assert property (i_timer_refresh_pulse |=> latch_r)
	else $error("timer set lost");

	// helper: cpu falls spent inside one refresh; a stuck refresh would starve the cpu
	logic [STATE_W-1:0] ref_falls_r;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ref_falls_r <= '0;
		end else if (!in_refresh) begin
			ref_falls_r <= '0;
		end else if (cpu_fall) begin
			ref_falls_r <= ref_falls_r + 1'b1;
		end
	end

	chk_refresh_bound:
	assert property (ref_falls_r <= REF_FALLS_MAX)
	else $error("refresh held too many cpu clocks");

	// per-state transition, strobe, ready and latch checks
	chk_access_close:
	assert property (cpu_fall && state_r == DRA_ACC_STROBE_B
		|=> state_r == DRA_IDLE && ctl_r.row_strobe_request_n)
	else $error("access did not close to idle");

	chk_access_row_low:
	assert property (cpu_fall && state_r == DRA_ACC_STROBE_A
		|=> state_r == DRA_ACC_STROBE_B && !ctl_r.row_strobe_request_n && ctl_r.refresh_request_n)
	else $error("access row strobe not held");

	chk_arm_advance:
	assert property (cpu_fall && state_r == DRA_REF_ARM
		|=> state_r == DRA_REF_STROBE_A && !ctl_r.row_strobe_request_n)
	else $error("refresh arm did not strobe");

	chk_strobe_advance:
	assert property (cpu_fall && state_r == DRA_REF_STROBE_A
		|=> state_r == DRA_REF_STROBE_B && !ctl_r.refresh_request_n)
	else $error("refresh strobe not held");

	chk_recover_row:
	assert property (state_r == DRA_REF_RECOVER |-> ctl_r.row_strobe_request_n && !ctl_r.refresh_request_n)
	else $error("recover strobes wrong");

	chk_rearm_strobes:
	assert property (state_r == DRA_ACC_REARM |-> ctl_r.refresh_request_n && ctl_r.row_strobe_request_n)
	else $error("rearm strobes wrong");

	chk_rearm_entry:
	assert property (state_r == DRA_ACC_REARM && $changed(state_r) |-> $past(state_r) == DRA_REF_RECOVER)
	else $error("rearm entered from wrong state");

	chk_refresh_entry:
	assert property (state_r == DRA_REF_ARM && $changed(state_r) |-> $past(state_r) == DRA_IDLE)
	else $error("refresh armed from wrong state");

	chk_latch_hold:
	assert property (latch_r && ctl_r.refresh_request_n |=> latch_r)
	else $error("pending refresh lost before service");

	chk_latch_cause:
	assert property ($rose(latch_r) |-> $past(i_timer_refresh_pulse))
	else $error("latch set without timer pulse");

	chk_access_ready:
	assert property (state_r == DRA_ACC_STROBE_A || state_r == DRA_ACC_STROBE_B
		|| state_r == DRA_IDLE |-> o_sync_ready)
	else $error("ready low outside collision");

	chk_ready_rearm:
	assert property (cpu_fall && state_r == DRA_REF_RECOVER && !i_dram_select_n
		|=> !o_sync_ready && state_r == DRA_ACC_REARM)
	else $error("ready released too early");

	chk_idle_strobes:
	assert property (state_r == DRA_IDLE |-> ctl_r.refresh_request_n && ctl_r.row_strobe_request_n)
	else $error("idle strobes not high");

	chk_strobe_low:
	assert property (state_r == DRA_REF_STROBE_B |-> !ctl_r.row_strobe_request_n && !ctl_r.refresh_request_n)
	else $error("refresh strobe released early");

	chk_latch_through:
	assert property (latch_r && state_r == DRA_ACC_STROBE_B |=> latch_r)
	else $error("deferred refresh dropped");

	chk_rearm_out:
	assert property (cpu_fall && state_r == DRA_ACC_REARM
		|=> ctl_r.refresh_request_n && !ctl_r.row_strobe_request_n)
	else $error("rearm did not start access");

	chk_ready_hold_arm:
	assert property (cpu_fall && state_r == DRA_REF_ARM && !i_dram_select_n
		|=> !o_sync_ready && state_r == DRA_REF_STROBE_A)
	else $error("no wait state in refresh arm");

endmodule // dra_arbiter

// ---- sim/dra_host_model.sv ----
// dra_host_model: cpu clock, dram select decode and refresh timer facing the arbiter
// assumes the 200 MHz system clock; cpu clock and timer pulse change on its rising edge, select decode is combinational
`timescale 1ns/1ps
module dra_host_model (
	// system
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// stimulus
	input  wire logic        i_req,
	input  wire logic [19:0] i_addr,
	input  wire logic        i_timer_en,
	// toward the arbiter
	output logic             o_cpu_clock_output,
	output logic             o_dram_select_n,
	output logic             o_timer_refresh_pulse
);
	import dra_pkg::*;
	// rows spread evenly, so no row waits longer than the period
	localparam int unsigned PERIOD = REFRESH_MS * 1000 * SYS_CLK_MHZ / REFRESH_ROWS;
	localparam int unsigned HALF   = CPU_CLK_RATIO / 2;
	int unsigned clk_cnt_r;
	int unsigned tmr_cnt_r;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			clk_cnt_r          <= 0;
			o_cpu_clock_output <= 1'b0;
		end else begin
			clk_cnt_r <= (clk_cnt_r == HALF - 1) ? 0 : clk_cnt_r + 1;
			if (clk_cnt_r == HALF - 1)
				o_cpu_clock_output <= !o_cpu_clock_output;
		end
	end
	// timer off restarts the interval, keeping directed scenarios undisturbed
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			tmr_cnt_r             <= 0;
			o_timer_refresh_pulse <= 1'b0;
		end else begin
			tmr_cnt_r             <= (!i_timer_en || tmr_cnt_r == PERIOD - 1) ? 0 : tmr_cnt_r + 1;
			o_timer_refresh_pulse <= i_timer_en && tmr_cnt_r == PERIOD - 1;
		end
	end
	assign o_dram_select_n = !(i_req && i_addr <= 20'h3FFFF);
endmodule // dra_host_model

// ---- sim/dram_refresh_arbiter_tb.sv ----
// dram_refresh_arbiter_tb: directed walks through access, refresh and collision sequences
// assumes dra_host_model supplies cpu clock, select decode and the refresh timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module dram_refresh_arbiter_tb;
	import dra_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        req = 1'b0;
	logic [19:0] addr = 20'h00000;
	logic        ten = 1'b0;
	logic        tpulse = 1'b0;
	logic        cpu_clk, sel_n, hpulse, rdy, latch;
	dra_ctl_t    ctl, ctl_q;
	dra_state_t  st;
	int          tests_run = 0;
	int          miscompares = 0;
	int          cycles = 0;
	always #2.5 clk = !clk;
	dra_host_model i_dra_host_model (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_addr(addr), .i_timer_en(ten),
		.o_cpu_clock_output(cpu_clk), .o_dram_select_n(sel_n), .o_timer_refresh_pulse(hpulse));
	dra_arbiter i_dra_arbiter (.i_clk_sys(clk), .i_rst(rst), .i_cpu_clock_output(cpu_clk), .i_dram_select_n(sel_n),
		.o_sync_ready(rdy), .i_timer_refresh_pulse(hpulse | tpulse), .o_latched_refresh_view(latch),
		.o_dram_ctl(ctl), .o_state(st));
	task automatic complete_run();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// both strobes high one cycle must not both be low the next
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
		if (ctl_q[2:1] === 2'b11)
			`CHK("strobes fell together", 1'b1, ctl[2:1] !== 2'b00)
		ctl_q = ctl;
	end
	// ends three edges after the fall, once the new state has landed
	task automatic step();
		@(posedge clk iff cpu_clk);
		@(posedge clk iff !cpu_clk);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic expect_st(input dra_state_t s, input logic r);
		`CHK("state", s, st)
		`CHK("refresh_request_n", s[2], ctl.refresh_request_n)
		`CHK("row_strobe_request_n", s[1], ctl.row_strobe_request_n)
		`CHK("column_strobe_request_n", s[1], ctl.column_strobe_request_n)
		`CHK("sync_ready", r, rdy)
	endtask
	// q: request held before each step, r: ready expected after it
	task automatic walk(input dra_state_t s[$], input logic [7:0] q, input logic [7:0] r, input logic [19:0] a);
		for (int i = 0; i < s.size(); i++) begin
			@(posedge clk);
			req  <= q[i];
			addr <= a;
			step();
			expect_st(s[i], r[i]);
		end
	endtask
	task automatic pulse1();
		@(posedge clk);
		tpulse <= 1'b1;
		@(posedge clk);
		tpulse <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		expect_st(DRA_IDLE, 1'b1);
		`CHK("latch after reset", 1'b0, latch)
		walk('{DRA_IDLE}, 8'h01, 8'hFF, 20'h40000);
		walk('{DRA_ACC_STROBE_A, DRA_ACC_STROBE_B, DRA_IDLE, DRA_ACC_STROBE_A, DRA_ACC_STROBE_B,
			DRA_IDLE}, 8'h1F, 8'hFF, 20'h3FFFF);
		// pulse held over the clear edge
		@(posedge clk);
		tpulse <= 1'b1;
		step();
		expect_st(DRA_REF_ARM, 1'b1);
		`CHK("latch set wins", 1'b1, latch)
		@(posedge clk);
		tpulse <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("latch cleared", 1'b0, latch)
		walk('{DRA_REF_STROBE_A, DRA_REF_STROBE_B, DRA_REF_RECOVER, DRA_IDLE}, 8'h00, 8'hFF, 20'h00000);
		pulse1();
		walk('{DRA_REF_ARM, DRA_REF_STROBE_A, DRA_REF_STROBE_B, DRA_REF_RECOVER, DRA_ACC_REARM,
			DRA_ACC_STROBE_A, DRA_ACC_STROBE_B, DRA_IDLE}, 8'h7E, 8'hE1, 20'h00000);
		pulse1();
		walk('{DRA_ACC_STROBE_A, DRA_ACC_STROBE_B, DRA_IDLE, DRA_REF_ARM, DRA_REF_STROBE_A,
			DRA_REF_STROBE_B, DRA_REF_RECOVER, DRA_IDLE}, 8'h01, 8'hFF, 20'h10000);
		// start on the first high cpu edge so the latch lands three system cycles before a fall
		@(posedge clk iff !cpu_clk);
		@(posedge clk iff cpu_clk);
		ten <= 1'b1;
		for (int i = 0; i < 3200 && latch !== 1'b1; i++)
			@(posedge clk);
		ten <= 1'b0;
		`CHK("timer latch", 1'b1, latch)
		walk('{DRA_REF_ARM, DRA_REF_STROBE_A, DRA_REF_STROBE_B, DRA_REF_RECOVER, DRA_IDLE}, 8'h00, 8'hFF, 20'h00000);
		walk('{DRA_ACC_STROBE_A}, 8'h01, 8'hFF, 20'h00000);
		@(posedge clk);
		rst <= 1'b1;
		req <= 1'b0;
		#1;
		expect_st(DRA_IDLE, 1'b1);
		@(posedge clk);
		rst <= 1'b0;
		complete_run();
	end
endmodule // dram_refresh_arbiter_tb
